// ### rtl/ssa_pkg.sv
package ssa_pkg;

  // ****************************************
  // Synchroniser lanes
  // ****************************************
  localparam int PIN_RXCLK = 0;
  localparam int PIN_RXDAT = 1;
  localparam int PIN_CDN = 2;
  localparam int PIN_EN = 3;
  localparam int PIN_RSTN = 4;
  localparam int PIN_N = 5;

  // ****************************************
  // Bus address bits
  // ****************************************
  localparam int ADR_RS = 0;
  localparam int ADR_HI = 1;

  // ****************************************
  // Register fields
  // ****************************************
  localparam int C1_RXRS = 0;
  localparam int C1_TXRS = 1;
  localparam int C1_STRIP = 2;
  localparam int C1_CLRSYNC = 3;
  localparam int C1_TIE = 4;
  localparam int C1_RIE = 5;
  localparam int C1_AC1 = 6;
  localparam int C1_AC2 = 7;
  localparam int C2_PC1 = 0;
  localparam int C2_PC2 = 1;
  localparam int C2_ONEBYTE = 2;
  localparam int C2_EIE = 7;
  localparam int C3_EXT = 0;
  localparam int C3_ONESYNC = 1;
  localparam int ST_RDA = 0;
  localparam int ST_DCD = 2;
  localparam int ST_OVR = 5;
  localparam int ST_IRQ = 7;
  localparam logic [1:0] AC_C2 = 2'h0;
  localparam logic [1:0] AC_C3 = 2'h1;
  localparam logic [1:0] AC_SYNC = 2'h2;

  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [7:0] C1_RST = 8'h03;
  localparam logic [7:0] C2_RST = 8'h00;
  localparam logic [7:0] C3_RST = 8'h00;
  localparam logic [7:0] SYNC_RST = 8'h00;
  localparam logic [7:0] SHIFT_RST = 8'hFF;
  localparam logic [2:0] CHAR_LAST = 3'h7;

  typedef enum logic [1:0] {
    RX_HUNT,
    RX_SECOND,
    RX_LOCKED
  } ssa_rxst_t;

endpackage

// ### rtl/ssa_rx_port.sv
`timescale 1ns/1ps

// What this block does
// - No sync codes stored before sync completes
// - Strip-sync drops sync codes after sync, except in external mode
// - Sync held until clear-sync, or carrier loss in external mode; clear-sync inhibits search
// - Characters enter FIFO, advance on enable pulses
// - One-byte mode: available when slot 3 full
// - Two-byte mode: available when slots 2,3 full
// - Interrupt when data available and enabled
// - FIFO read clears available and interrupt
// - Remaining characters shift, flags set again
// - Push into full slot 1 sets overrun unless slot 1 moves to slot 2 in that cycle
// - Overrun interrupts when error enable set
// - Overrun clears after status then data read
// - Data driven only on reads
// - Enable clock gates transfers, moves FIFO
// - Direction picks read or write registers
// - Respond only when selected
// - Address bit 0 is register select
// - Interrupt pin active low, open drain
// - Reset pin low forces control bits
// - Sections stay reset; bits locked during reset
// - Receiver samples on rising serial clock
// - External mode syncs on carrier detect
// - Receiver reset clears logic, shift to ones
module ssa_rx_port
  import ssa_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [1:0] wb_adr_i,
  input wire logic [0:0] wb_sel_i,
  input wire logic [7:0] wb_dat_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic busEnableClock,
  input wire logic devResetN,
  input wire logic rxClk,
  input wire logic rxData,
  input wire logic carrierDetectN,
  output logic irqOutN,
  output logic irqOeN,
  output logic modemCtrlOut
);

  // ****************************************
  // Pin synchronisers and edges
  // ****************************************
  logic [PIN_N-1:0] syncA_ff;
  logic [PIN_N-1:0] syncB_ff;
  logic [PIN_N-1:0] prevB_ff;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      syncA_ff <= '0;
      syncB_ff <= '0;
      prevB_ff <= '0;
    end else begin
      syncA_ff <= {devResetN, busEnableClock,
                   carrierDetectN, rxData, rxClk};
      syncB_ff <= syncA_ff;
      prevB_ff <= syncB_ff;
    end
  end

  wire rxEdge = syncB_ff[PIN_RXCLK] & ~prevB_ff[PIN_RXCLK];
  wire enPulse = ~syncB_ff[PIN_EN] & prevB_ff[PIN_EN];
  wire rxBit = syncB_ff[PIN_RXDAT];
  wire cdOn = ~syncB_ff[PIN_CDN];
  wire devRstLow = ~syncB_ff[PIN_RSTN];

  // ****************************************
  // Bus decode
  // ****************************************
  logic ack_ff;
  logic [7:0] datOut_ff;
  logic [7:0] ctl1_ff;
  logic [7:0] ctl2_ff;
  logic [7:0] ctl3_ff;
  logic [7:0] syncCode_ff;

  // Accesses complete only on an enable falling edge
  wire req = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire go = req & enPulse;
  wire adrOk = ~wb_adr_i[ADR_HI];
  wire rsel = wb_adr_i[ADR_RS];
  wire rd = go & ~wb_we_i & adrOk;
  wire wr = go & wb_we_i & adrOk & wb_sel_i[0];
  wire [1:0] acSel = {ctl1_ff[C1_AC2], ctl1_ff[C1_AC1]};
  wire stRead = rd & ~rsel;
  wire fifoRd = rd & rsel;
  wire c1Wr = wr & ~rsel;
  wire c2Wr = wr & rsel & (acSel == AC_C2);
  wire c3Wr = wr & rsel & (acSel == AC_C3);
  wire scWr = wr & rsel & (acSel == AC_SYNC);

  // ****************************************
  // Control registers
  // ****************************************
  wire rxRs = ctl1_ff[C1_RXRS];
  wire txRs = ctl1_ff[C1_TXRS];
  wire strip = ctl1_ff[C1_STRIP];
  wire clearSync = ctl1_ff[C1_CLRSYNC];
  wire rx_irq_enable = ctl1_ff[C1_RIE];
  wire error_irq_enable = ctl2_ff[C2_EIE];
  wire oneByte = ctl2_ff[C2_ONEBYTE];
  wire extSync = ctl3_ff[C3_EXT];
  wire oneSync = ctl3_ff[C3_ONESYNC];

  // Bits that the reset pin owns are forced to fixed values while it is low
  logic [7:0] nxt_ctl1;
  logic [7:0] nxt_ctl2;
  logic [7:0] nxt_ctl3;

  always_comb begin
    nxt_ctl1 = c1Wr ? wb_dat_i : ctl1_ff;
    nxt_ctl2 = c2Wr ? wb_dat_i : ctl2_ff;
    nxt_ctl3 = c3Wr ? wb_dat_i : ctl3_ff;
    if (devRstLow) begin
      nxt_ctl1[C1_RXRS] = 1'b1;
      nxt_ctl1[C1_TXRS] = 1'b1;
      nxt_ctl2[C2_PC1] = 1'b0;
      nxt_ctl2[C2_PC2] = 1'b0;
      nxt_ctl2[C2_EIE] = 1'b0;
      nxt_ctl3[C3_EXT] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctl1_ff <= C1_RST;
      ctl2_ff <= C2_RST;
      ctl3_ff <= C3_RST;
      syncCode_ff <= SYNC_RST;
    end else begin
      ctl1_ff <= nxt_ctl1;
      ctl2_ff <= nxt_ctl2;
      ctl3_ff <= nxt_ctl3;
      if (scWr) begin
        syncCode_ff <= wb_dat_i;
      end
    end
  end

  // ****************************************
  // Character framing
  // ****************************************
  ssa_rxst_t state_ff;
  ssa_rxst_t nxt_state;
  logic [7:0] shift_ff;
  logic [2:0] bitCnt_ff;
  logic [2:0] nxt_bitCnt;
  logic push;

  wire [7:0] shNext = {rxBit, shift_ff[7:1]};
  wire syncHit = shNext == syncCode_ff;
  wire charDone = bitCnt_ff == CHAR_LAST;

  always_comb begin
    nxt_state = state_ff;
    nxt_bitCnt = bitCnt_ff;
    push = 1'b0;
    if (rxRs) begin
      nxt_state = RX_HUNT;
      nxt_bitCnt = '0;
    end else if (clearSync) begin
      nxt_state = RX_HUNT;
      nxt_bitCnt = '0;
    end else if (rxEdge) begin
      nxt_bitCnt = bitCnt_ff + 3'h1;
      unique case (state_ff)
        RX_HUNT: begin
          nxt_bitCnt = '0;
          if (extSync && cdOn) begin
            // The bit seen with carrier is the first data bit
            nxt_state = RX_LOCKED;
            nxt_bitCnt = 3'h1;
          end else if (!extSync && syncHit) begin
            nxt_state = oneSync ? RX_LOCKED : RX_SECOND;
          end
        end
        RX_SECOND: begin
          if (charDone) begin
            nxt_state = syncHit ? RX_LOCKED : RX_HUNT;
          end
        end
        RX_LOCKED: begin
          if (extSync && !cdOn) begin
            nxt_state = RX_HUNT;
            nxt_bitCnt = '0;
          end else if (charDone) begin
            push = !(strip && !extSync && syncHit);
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= RX_HUNT;
      bitCnt_ff <= '0;
      shift_ff <= SHIFT_RST;
    end else begin
      state_ff <= nxt_state;
      bitCnt_ff <= nxt_bitCnt;
      if (rxRs) begin
        shift_ff <= SHIFT_RST;
      end else if (rxEdge) begin
        shift_ff <= shNext;
      end
    end
  end

  // ****************************************
  // Three-slot receive FIFO
  // ****************************************
  logic [7:0] slot_ff [1:3];
  logic [3:1] valid_ff;
  logic ovr_ff;
  logic ovrSeen_ff;

  // One step per enable pulse; a slot moves only into an empty one
  wire mv23 = enPulse & valid_ff[2] & ~valid_ff[3];
  wire mv12 = enPulse & valid_ff[1] & ~valid_ff[2];
  wire pop = fifoRd & valid_ff[3];
  wire ovrEvt = push & valid_ff[1] & ~mv12;
  wire ovrClr = fifoRd & ovrSeen_ff;
  wire rx_data_avail_flag = oneByte ? valid_ff[3]
                     : valid_ff[3] & valid_ff[2];
  wire irqStat = (rx_irq_enable & rx_data_avail_flag) | (error_irq_enable & ovr_ff);

  wire [3:1] nxt_valid = {
    (valid_ff[3] & ~pop) | mv23,
    (valid_ff[2] & ~mv23) | mv12,
    (valid_ff[1] & ~mv12) | push
  };

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      valid_ff <= '0;
      slot_ff[1] <= '0;
      slot_ff[2] <= '0;
      slot_ff[3] <= '0;
    end else begin
      valid_ff <= rxRs ? 3'h0 : nxt_valid;
      if (push) begin
        slot_ff[1] <= shNext;
      end
      if (mv12) begin
        slot_ff[2] <= slot_ff[1];
      end
      if (mv23) begin
        slot_ff[3] <= slot_ff[2];
      end
    end
  end

  // New overrun wins over a pending clear and re-arms the status read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ovr_ff <= 1'b0;
      ovrSeen_ff <= 1'b0;
    end else if (rxRs) begin
      ovr_ff <= 1'b0;
      ovrSeen_ff <= 1'b0;
    end else begin
      ovr_ff <= ovrEvt | (ovr_ff & ~ovrClr);
      ovrSeen_ff <= ~ovrEvt & ~ovrClr
                    & (ovrSeen_ff | (stRead & ovr_ff));
    end
  end

  // ****************************************
  // Read data, acknowledge and pins
  // ****************************************
  logic [7:0] status;

  always_comb begin
    status = '0;
    status[ST_RDA] = rx_data_avail_flag;
    status[ST_DCD] = cdOn;
    status[ST_OVR] = ovr_ff;
    status[ST_IRQ] = irqStat;
  end

  // Unmapped or write cycles return zero
  wire [7:0] rdMux = rsel ? slot_ff[3] : status;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ack_ff <= 1'b0;
      datOut_ff <= '0;
      irqOeN <= 1'b1;
      irqOutN <= 1'b0;
      modemCtrlOut <= 1'b1;
    end else begin
      ack_ff <= go;
      datOut_ff <= rd ? rdMux : 8'h00;
      irqOeN <= ~irqStat;
      irqOutN <= 1'b0;
      modemCtrlOut <= ~ctl2_ff[C2_PC1];
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = datOut_ff;

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  chk_ack_gated: assert property (
    wb_ack_o |-> $past(enPulse) && $past(wb_cyc_i & wb_stb_i))
    else $error("ack without enable edge or request");

  chk_write_quiet: assert property (
    (wb_ack_o && $past(wb_we_i)) |-> wb_dat_o == 8'h00)
    else $error("data driven on a write");

  chk_read_clears: assert property (
    (fifoRd && valid_ff[3] && !rxRs) |=> !rx_data_avail_flag)
    else $error("read left data available");

  chk_ovr_set: assert property (
    (ovrEvt && !rxRs) |=> ovr_ff)
    else $error("overrun not flagged");

  chk_ovr_hold: assert property (
    (ovr_ff && !ovrSeen_ff && !rxRs) |=> ovr_ff)
    else $error("overrun cleared unseen");

  chk_rx_irq: assert property (
    (rx_irq_enable && rx_data_avail_flag) |=> !irqOeN)
    else $error("receive interrupt missing");

  chk_err_irq: assert property (
    (error_irq_enable && ovr_ff) |=> !irqOeN)
    else $error("error interrupt missing");

  chk_reset_bits: assert property (
    devRstLow |=> rxRs && txRs && !error_irq_enable && !extSync)
    else $error("reset pin did not force bits");

  chk_clear_hunt: assert property (
    clearSync |=> state_ff == RX_HUNT)
    else $error("sync kept during clear");

  chk_push_locked: assert property (
    push |-> state_ff == RX_LOCKED)
    else $error("character stored before sync");

  chk_rxrs_clear: assert property (
    rxRs |=> valid_ff == 3'h0 && shift_ff == SHIFT_RST && !ovr_ff)
    else $error("receiver reset incomplete");

endmodule

// ### verification/ssa_serial_src.sv
`timescale 1ns/1ps

// ********
// Serial source with its own 64 ns link clock
// ********
module ssa_serial_src (
  output logic rxClk,
  output logic rxData,
  output logic carrierDetectN
);
  initial begin
    rxClk = 1'b0;
    rxData = 1'b1;
    carrierDetectN = 1'b1;
  end

  // Clock stands low between frames; data moves only while it is low
  // Non-blocking, so a change never races the sampling clock
  task automatic sendByte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      rxData <= b[i];
      #32 rxClk <= 1'b1;
      #32 rxClk <= 1'b0;
    end
    // Inverse of the last bit, so a stale bit never reads as data
    rxData <= ~b[7];
    #32;
  endtask

  task automatic setCarrier(input logic present);
    carrierDetectN <= ~present;
  endtask
endmodule

// ### verification/testbench.sv
`timescale 1ns/1ps

module testbench;
  import ssa_pkg::*;
  logic refClk = 1'b0;
  logic rst = 1'b1;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [1:0] wbAdr = 2'h0;
  logic [0:0] wbSel = 1'h1;
  logic [7:0] wbDatI = 8'h00;
  logic [7:0] wbDatO;
  logic wbAck;
  logic enClk = 1'b0;
  logic devRstN = 1'b0;
  logic rxClk;
  logic rxData;
  logic cdN;
  logic irqN;
  logic irqOeN;
  logic modem;
  int errorCnt = 0;
  int testsRun = 0;
  int enCnt = 0;

  ssa_rx_port dut (.ref_clk(refClk), .rst(rst), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .busEnableClock(enClk), .devResetN(devRstN), .rxClk(rxClk),
    .rxData(rxData), .carrierDetectN(cdN), .irqOutN(irqN),
    .irqOeN(irqOeN), .modemCtrlOut(modem));
  ssa_serial_src src (.rxClk(rxClk), .rxData(rxData),
    .carrierDetectN(cdN));

  initial begin
    forever #2.5 refClk = ~refClk;
  end

  // 1 MHz enable clock derived from the 200 MHz system clock
  always @(posedge refClk) begin
    enCnt <= (enCnt == 99) ? 0 : enCnt + 1;
    if (enCnt == 99) enClk <= ~enClk;
  end

  // ********
  // Shared tasks
  // ********
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    testsRun++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      errorCnt++;
    end
  endtask

  task automatic bus(input logic we, input logic [1:0] adr,
    input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge refClk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= wd;
    do begin
      @(posedge refClk);
      n++;
    end while (wbAck !== 1'b1 && n < 1000);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (n >= 1000) chk("bus answer", 8'h01, 8'h00);
  endtask

  task automatic wr(input logic [1:0] adr, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, adr, d, r);
  endtask

  task automatic rdChk(input logic [1:0] adr, input logic [7:0] m,
    input logic [7:0] exp, input string nm);
    logic [7:0] r;
    bus(1'b0, adr, 8'h00, r);
    chk(nm, exp, r & m);
  endtask

  task automatic waitIrq(input logic lvl, input int lim);
    int n;
    n = 0;
    while (irqOeN !== lvl && n < lim) begin
      @(posedge refClk);
      n++;
    end
    chk("irq enable", {7'h00, lvl}, {7'h00, irqOeN});
  endtask

  // ********
  // Scenarios
  // ********
  task automatic testReset();
    chk("irq line", 8'h01, {7'h00, irqOeN});
    chk("irq value", 8'h00, {7'h00, irqN});
    chk("modem", 8'h01, {7'h00, modem});
    rdChk(2'h0, 8'hFF, 8'h00, "status");
  endtask

  task automatic testLock();
    wr(2'h0, 8'h00);
    wr(2'h1, 8'h01);
    chk("modem locked", 8'h01, {7'h00, modem});
    devRstN <= 1'b1;
    repeat (4) @(posedge refClk);
    wr(2'h1, 8'h01);
    repeat (2) @(posedge refClk);
    chk("modem", 8'h00, {7'h00, modem});
  endtask

  task automatic setup();
    wr(2'h0, 8'h83);
    wr(2'h1, 8'h5A);
    wr(2'h0, 8'h43);
    wr(2'h1, 8'h02);
    wr(2'h0, 8'h03);
    wr(2'h1, 8'h84);
    wr(2'h0, 8'h24);
  endtask

  task automatic testRecv();
    src.sendByte(8'hFF);
    src.sendByte(8'h5A);
    src.sendByte(8'h5A);
    src.sendByte(8'h3C);
    waitIrq(1'b0, 4000);
    rdChk(2'h0, 8'hFF, 8'h81, "status");
    rdChk(2'h1, 8'hFF, 8'h3C, "fifo");
    waitIrq(1'b1, 3);
    rdChk(2'h0, 8'h81, 8'h00, "status");
  endtask

  task automatic testShift();
    src.sendByte(8'h11);
    repeat (250) @(posedge refClk);
    src.sendByte(8'h22);
    waitIrq(1'b0, 4000);
    rdChk(2'h1, 8'hFF, 8'h11, "fifo");
    waitIrq(1'b1, 5);
    waitIrq(1'b0, 1000);
    rdChk(2'h0, 8'h81, 8'h81, "status");
    rdChk(2'h1, 8'hFF, 8'h22, "fifo");
  endtask

  task automatic testOverrun();
    wr(2'h0, 8'h04);
    // Spaced so that three settle and the fourth overwrites slot 1
    for (int i = 1; i <= 4; i++) begin
      src.sendByte(8'(i));
      repeat (250) @(posedge refClk);
    end
    waitIrq(1'b0, 4000);
    rdChk(2'h1, 8'hFF, 8'h01, "fifo");
    rdChk(2'h0, 8'h20, 8'h20, "overrun");
    rdChk(2'h1, 8'hFF, 8'h02, "fifo");
    rdChk(2'h0, 8'h20, 8'h00, "overrun");
    waitIrq(1'b1, 5);
    rdChk(2'h1, 8'hFF, 8'h04, "fifo");
  endtask

  task automatic testTwoByte();
    wr(2'h0, 8'h24);
    wr(2'h1, 8'h80);
    src.sendByte(8'hA1);
    repeat (700) @(posedge refClk);
    rdChk(2'h0, 8'h81, 8'h00, "one of two");
    src.sendByte(8'hB2);
    waitIrq(1'b0, 4000);
    rdChk(2'h0, 8'h81, 8'h81, "two ready");
    rdChk(2'h1, 8'hFF, 8'hA1, "fifo");
    rdChk(2'h0, 8'h81, 8'h00, "one left");
    rdChk(2'h1, 8'hFF, 8'hB2, "fifo");
  endtask

  task automatic testExt();
    wr(2'h1, 8'h84);
    wbSel <= 1'b0;
    wr(2'h1, 8'h85);
    wbSel <= 1'b1;
    repeat (2) @(posedge refClk);
    chk("masked write", 8'h01, {7'h00, modem});
    wr(2'h0, 8'h61);
    wr(2'h1, 8'h01);
    wr(2'h0, 8'h60);
    src.setCarrier(1'b1);
    repeat (4) @(posedge refClk);
    rdChk(2'h0, 8'h04, 8'h04, "carrier");
    src.sendByte(8'hC3);
    waitIrq(1'b0, 4000);
    rdChk(2'h1, 8'hFF, 8'hC3, "ext fifo");
    wr(2'h0, 8'h28);
    src.sendByte(8'h77);
    repeat (600) @(posedge refClk);
    rdChk(2'h0, 8'h01, 8'h00, "clear sync");
    src.setCarrier(1'b0);
    repeat (4) @(posedge refClk);
    rdChk(2'h0, 8'h04, 8'h00, "carrier");
  endtask

  task automatic testUnmapped();
    wr(2'h2, 8'hFF);
    rdChk(2'h2, 8'hFF, 8'h00, "unmapped");
    @(posedge refClk);
    chk("idle data", 8'h00, wbDatO);
  endtask

  task automatic testDone();
    if (errorCnt == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge refClk);
    rst <= 1'b0;
    @(posedge refClk);
    testReset();
    testLock();
    setup();
    testRecv();
    testShift();
    testOverrun();
    testTwoByte();
    testExt();
    testUnmapped();
    testDone();
  end

  // About 40 bus cycles of up to 200 clocks plus serial traffic
  initial begin
    repeat (60000) @(posedge refClk);
    errorCnt++;
    testDone();
  end
endmodule
